// [inc/ctu_pkg.sv]
`default_nettype none
package ctu_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_MATCH_A = 8'h08;
    localparam logic [7:0] ADDR_MATCH_B = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_W = 17;
    localparam int CLK_LSB = 0;
    localparam int CLR_LSB = 4;
    localparam int ADC_BIT = 7;
    localparam int DTC_A_BIT = 8;
    localparam int DTC_B_BIT = 9;
    localparam int OUT_A_LSB = 10;
    localparam int OUT_B_LSB = 12;
    localparam int PERIODIC_BIT = 14;
    localparam int LEVEL_BIT = 15;
    localparam int OUT_OFF_BIT = 16;

    // ------------------------------------------------------------
    // Status and mask bits
    // ------------------------------------------------------------
    localparam int EV_W = 3;
    localparam int EV_OVF = 0;
    localparam int EV_MATCH_A = 1;
    localparam int EV_MATCH_B = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [16:0] CTRL_RST = 17'h0_0000;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] MATCH_RST = 16'hFFFF;
    localparam logic [2:0] EV_RST = 3'h0;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CLK_OFF = 4'h0,
        CLK_EXT_RISE = 4'h1,
        CLK_EXT_FALL = 4'h2,
        CLK_EXT_BOTH = 4'h3,
        CLK_DIV_1 = 4'h4,
        CLK_DIV_2 = 4'h5,
        CLK_DIV_8 = 4'h6,
        CLK_DIV_32 = 4'h7,
        CLK_DIV_64 = 4'h8,
        CLK_DIV_1024 = 4'h9,
        CLK_DIV_8192 = 4'hA
    } ctu_clk_t;

    typedef enum logic [2:0] {
        CLR_NONE = 3'h0,
        CLR_MATCH_A = 3'h1,
        CLR_MATCH_B = 3'h2,
        CLR_RST_EDGE = 3'h3,
        CLR_RST_HIGH = 3'h4
    } ctu_clr_t;

    typedef enum logic [1:0] {
        OUT_KEEP = 2'h0,
        OUT_LOW = 2'h1,
        OUT_HIGH = 2'h2,
        OUT_TOGGLE = 2'h3
    } ctu_out_t;
endpackage
`default_nettype wire

// [src/ctu_timer.sv]
`default_nettype none
// How it works
// - Two 8-bit channels form one 16-bit counter stepping on the selected count clock.
// - Count clock is off or the bus clock divided by 1,2,8,32,64,1024,8192.
// - External clock mode counts on rising, falling or both edges of the clock pin.
// - Clearing is off, or to zero after compare match A or match B.
// - Edge-reset mode clears the counter on a rising edge of the reset pin.
// - Level-reset mode holds the counter cleared while the reset pin is high.
// - With the converter trigger enabled, each match A issues a start request.
// - Match A and match B each have an enable for a transfer request.
// - Match A drives the output pin unchanged, low, high or toggled.
// - Match B drives the output pin with its own independent action.
// - The unit drives the output pin of its lower channel.
// - Software loads the 16-bit count and both 16-bit compare values.
// - Overflow, match A and match B raise separately enabled interrupts.
// - Periodic mode starts the pin at the chosen level, or leaves it undriven.
// - Periodic mode has transfer enables at pulse-width point and period end.
// - Periodic mode keeps the converter trigger available on the unit.
// - The unit is a lower channel paired with the next upper channel.
module ctu_timer #(
    parameter int ADDR_W = 8,
    parameter int PRE_W = 13
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    // External pins
    input wire logic ext_count_clock_in,
    input wire logic ext_counter_reset_in,
    output var logic timer_output_pin,
    output var logic timer_output_pin_oe,
    // Requests to other blocks
    output var logic adc_start_req,
    output var logic dtc_req,
    output var logic irq
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W < 8) begin : g_bad_addr
        $error("ADDR_W must be at least 8");
    end
    if (PRE_W != 13) begin : g_bad_pre
        $error("PRE_W must be 13 to serve the divide by 8192");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ctu_pkg::CTRL_W-1:0] ctrl;
        logic [15:0] count;
        logic [15:0] match_a;
        logic [15:0] match_b;
        logic [ctu_pkg::EV_W-1:0] status;
        logic [ctu_pkg::EV_W-1:0] mask;
        logic [PRE_W-1:0] pre;
        logic [1:0] clk_sync;
        logic [1:0] rst_sync;
        logic clk_prev;
        logic rst_prev;
        logic per_prev;
        logic pin;
        logic pin_oe;
        logic adc_req;
        logic dtc_req;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ctu_state_t;

    ctu_state_t st;
    ctu_state_t next_st;

    logic tick;
    logic lo_wrap;
    logic match_a_ev;
    logic match_b_ev;
    logic ovf_ev;
    logic adc_en;
    logic periodic;
    logic level;
    logic wr_done;
    logic clk_rise;
    logic clk_fall;
    logic rst_rise;
    ctu_pkg::ctu_clk_t clk_sel;
    ctu_pkg::ctu_clr_t clr_sel;
    ctu_pkg::ctu_out_t act_a;
    ctu_pkg::ctu_out_t act_b;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic div_tick(input logic [PRE_W-1:0] pre, input int unsigned n);
        logic [PRE_W-1:0] m;
        m = PRE_W'(n - 1);
        return (pre & m) == '0;
    endfunction

    function automatic logic count_tick(input ctu_pkg::ctu_clk_t sel,
                                        input logic [PRE_W-1:0] pre,
                                        input logic rise,
                                        input logic fall);
        logic t;
        t = 1'b0;
        unique case (sel)
            ctu_pkg::CLK_OFF: t = 1'b0;
            ctu_pkg::CLK_EXT_RISE: t = rise;
            ctu_pkg::CLK_EXT_FALL: t = fall;
            ctu_pkg::CLK_EXT_BOTH: t = rise | fall;
            ctu_pkg::CLK_DIV_1: t = 1'b1;
            ctu_pkg::CLK_DIV_2: t = div_tick(pre, 2);
            ctu_pkg::CLK_DIV_8: t = div_tick(pre, 8);
            ctu_pkg::CLK_DIV_32: t = div_tick(pre, 32);
            ctu_pkg::CLK_DIV_64: t = div_tick(pre, 64);
            ctu_pkg::CLK_DIV_1024: t = div_tick(pre, 1024);
            ctu_pkg::CLK_DIV_8192: t = div_tick(pre, 8192);
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    function automatic logic apply_action(input ctu_pkg::ctu_out_t act, input logic pin);
        logic r;
        r = pin;
        unique case (act)
            ctu_pkg::OUT_KEEP: r = pin;
            ctu_pkg::OUT_LOW: r = 1'b0;
            ctu_pkg::OUT_HIGH: r = 1'b1;
            ctu_pkg::OUT_TOGGLE: r = ~pin;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------
    assign clk_sel = ctu_pkg::ctu_clk_t'(st.ctrl[ctu_pkg::CLK_LSB +: 4]);
    assign clr_sel = ctu_pkg::ctu_clr_t'(st.ctrl[ctu_pkg::CLR_LSB +: 3]);
    assign act_a = ctu_pkg::ctu_out_t'(st.ctrl[ctu_pkg::OUT_A_LSB +: 2]);
    assign act_b = ctu_pkg::ctu_out_t'(st.ctrl[ctu_pkg::OUT_B_LSB +: 2]);
    assign adc_en = st.ctrl[ctu_pkg::ADC_BIT];
    assign periodic = st.ctrl[ctu_pkg::PERIODIC_BIT];
    assign level = st.ctrl[ctu_pkg::LEVEL_BIT];
    assign wr_done = psel & penable & st.pready & pwrite;

    // Edge detectors read only the second synchroniser stage.
    assign clk_rise = st.clk_sync[1] & ~st.clk_prev;
    assign clk_fall = ~st.clk_sync[1] & st.clk_prev;
    assign rst_rise = st.rst_sync[1] & ~st.rst_prev;

    // A match is taken on the tick that leaves the compare value, so a
    // clear-on-match period is compare value plus one count clocks.
    assign tick = count_tick(clk_sel, st.pre, clk_rise, clk_fall);
    assign lo_wrap = st.count[7:0] == 8'hFF;
    assign match_a_ev = tick & (st.count == st.match_a);
    assign match_b_ev = tick & (st.count == st.match_b);
    assign ovf_ev = tick & (st.count == 16'hFFFF);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] lo;
        logic [7:0] hi;
        logic [ctu_pkg::EV_W-1:0] ev;
        logic [ctu_pkg::EV_W-1:0] rd_clr;
        logic hit;
        logic [31:0] rd;
        lo = st.count[7:0];
        hi = st.count[15:8];
        ev = '0;
        rd_clr = '0;
        hit = 1'b1;
        rd = '0;
        next_st = st;

        next_st.clk_sync = {st.clk_sync[0], ext_count_clock_in};
        next_st.rst_sync = {st.rst_sync[0], ext_counter_reset_in};
        next_st.clk_prev = st.clk_sync[1];
        next_st.rst_prev = st.rst_sync[1];
        next_st.pre = st.pre + PRE_W'(1);
        next_st.per_prev = periodic;

        // Lower and upper channel make one contiguous count.
        if (tick) begin
            lo = st.count[7:0] + 8'd1;
            hi = st.count[15:8] + {7'd0, lo_wrap};
        end
        next_st.count = {hi, lo};

        if ((clr_sel == ctu_pkg::CLR_MATCH_A && match_a_ev)
                || (clr_sel == ctu_pkg::CLR_MATCH_B && match_b_ev)) begin
            next_st.count = ctu_pkg::COUNT_RST;
        end
        if (clr_sel == ctu_pkg::CLR_RST_EDGE && rst_rise) begin
            next_st.count = ctu_pkg::COUNT_RST;
        end
        if (clr_sel == ctu_pkg::CLR_RST_HIGH && st.rst_sync[1]) begin
            next_st.count = ctu_pkg::COUNT_RST;
        end
        if (periodic && match_b_ev) begin
            next_st.count = ctu_pkg::COUNT_RST;
        end

        // Output pin; when both hit together match B wins in periodic mode, else its action applies to match A's result.
        if (periodic) begin
            next_st.pin_oe = ~st.ctrl[ctu_pkg::OUT_OFF_BIT];
            if (!st.per_prev) begin
                next_st.pin = level;
            end else if (match_b_ev) begin
                next_st.pin = level;
            end else if (match_a_ev) begin
                next_st.pin = ~level;
            end
        end else begin
            next_st.pin_oe = 1'b1;
            if (match_a_ev) begin
                next_st.pin = apply_action(act_a, st.pin);
            end
            if (match_b_ev) begin
                next_st.pin = apply_action(act_b, next_st.pin);
            end
        end

        // In periodic mode the same enables serve pulse-width and period ends.
        next_st.adc_req = match_a_ev & adc_en;
        next_st.dtc_req = (match_a_ev & st.ctrl[ctu_pkg::DTC_A_BIT])
                        | (match_b_ev & st.ctrl[ctu_pkg::DTC_B_BIT]);

        ev[ctu_pkg::EV_OVF] = ovf_ev;
        ev[ctu_pkg::EV_MATCH_A] = match_a_ev;
        ev[ctu_pkg::EV_MATCH_B] = match_b_ev;

        // ---- APB: one wait state, read data latched as pready rises.
        unique case (paddr[7:0])
            ctu_pkg::ADDR_CTRL: rd = 32'(st.ctrl);
            ctu_pkg::ADDR_COUNT: rd = 32'(st.count);
            ctu_pkg::ADDR_MATCH_A: rd = 32'(st.match_a);
            ctu_pkg::ADDR_MATCH_B: rd = 32'(st.match_b);
            ctu_pkg::ADDR_STATUS: rd = 32'(st.status);
            ctu_pkg::ADDR_MASK: rd = 32'(st.mask);
            default: hit = 1'b0;
        endcase
        if (ADDR_W > 8 && paddr[ADDR_W-1:8] != '0) begin
            hit = 1'b0;
            rd = '0;
        end

        next_st.pready = psel & penable & ~st.pready;
        if (psel && penable && !st.pready) begin
            next_st.prdata = pwrite ? 32'h0000_0000 : rd;
            next_st.pslverr = ~hit;
        end

        if (psel && penable && st.pready) begin
            if (pwrite && !st.pslverr) begin
                unique case (paddr[7:0])
                    ctu_pkg::ADDR_CTRL: next_st.ctrl = pwdata[ctu_pkg::CTRL_W-1:0];
                    ctu_pkg::ADDR_COUNT: next_st.count = pwdata[15:0];
                    ctu_pkg::ADDR_MATCH_A: next_st.match_a = pwdata[15:0];
                    ctu_pkg::ADDR_MATCH_B: next_st.match_b = pwdata[15:0];
                    ctu_pkg::ADDR_MASK: next_st.mask = pwdata[ctu_pkg::EV_W-1:0];
                    default: next_st.ctrl = st.ctrl;
                endcase
            end
            // Only the bits software actually saw are cleared.
            if (!pwrite && paddr[7:0] == ctu_pkg::ADDR_STATUS) begin
                rd_clr = st.prdata[ctu_pkg::EV_W-1:0];
            end
        end

        // A new event in the clearing cycle survives the clear.
        next_st.status = (st.status & ~rd_clr) | ev;
        next_st.irq = |(next_st.status & next_st.mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.ctrl <= ctu_pkg::CTRL_RST;
            st.count <= ctu_pkg::COUNT_RST;
            st.match_a <= ctu_pkg::MATCH_RST;
            st.match_b <= ctu_pkg::MATCH_RST;
            st.status <= ctu_pkg::EV_RST;
            st.mask <= ctu_pkg::EV_RST;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign timer_output_pin = st.pin;
    assign timer_output_pin_oe = st.pin_oe;
    assign adc_start_req = st.adc_req;
    assign dtc_req = st.dtc_req;
    assign irq = st.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic quiet;
    assign quiet = !wr_done && clr_sel == ctu_pkg::CLR_NONE && !periodic;

    AST_HALT: assert property ((clk_sel == ctu_pkg::CLK_OFF && quiet)
        |=> st.count == $past(st.count))
        else $error("counter moved with the count clock off");
    AST_DIV1: assert property ((clk_sel == ctu_pkg::CLK_DIV_1 && quiet)
        |=> st.count == 16'($past(st.count) + 16'd1))
        else $error("divide by one did not count every cycle");
    AST_EXT_RISE: assert property ((clk_sel == ctu_pkg::CLK_EXT_RISE && quiet)
        |=> st.count == 16'($past(st.count) + {15'd0, $past(clk_rise)}))
        else $error("external rising edge count wrong");
    AST_CLR_A: assert property ((match_a_ev && clr_sel == ctu_pkg::CLR_MATCH_A
        && !wr_done) |=> st.count == 16'h0000)
        else $error("counter not cleared after match A");
    AST_LEVEL: assert property ((clr_sel == ctu_pkg::CLR_RST_HIGH && st.rst_sync[1]
        && !wr_done) |=> st.count == 16'h0000)
        else $error("counter not held by reset level");
    AST_ADC: assert property (adc_start_req |-> $past(match_a_ev) && $past(adc_en))
        else $error("converter request without enabled match A");
    AST_TOGGLE: assert property ((match_a_ev && !periodic && act_a == ctu_pkg::OUT_TOGGLE
        && act_b == ctu_pkg::OUT_KEEP) |=> timer_output_pin != $past(timer_output_pin))
        else $error("pin did not toggle on match A");
    AST_CASCADE: assert property ((tick && lo_wrap && quiet)
        |=> st.count[15:8] == 8'($past(st.count[15:8]) + 8'd1))
        else $error("upper channel did not step on lower overflow");
    AST_IRQ: assert property (irq == |(st.status & st.mask))
        else $error("interrupt line disagrees with status and mask");
    AST_PERIOD: assert property ((periodic && st.per_prev && match_b_ev && !wr_done)
        |=> st.count == 16'h0000 && timer_output_pin == $past(level))
        else $error("period end did not restore pin and clear counter");
endmodule
`default_nettype wire

// [bench/ctu_pin_model.sv]
`default_nettype none
module ctu_pin_model (
    // Clock
    input wire logic pclk,
    // Pins towards the timer
    output var logic clk_pin,
    output var logic rst_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        clk_pin = 1'b0;
        rst_pin = 1'b0;
    end

    // Four cycles per level, so the two-flop synchroniser can never miss one.
    task automatic hold(input logic clk_v, input logic rst_v);
        @(posedge pclk);
        clk_pin <= clk_v;
        rst_pin <= rst_v;
        repeat (3) @(posedge pclk);
    endtask

    task automatic pulse_clk();
        hold(1'b1, 1'b0);
        hold(1'b0, 1'b0);
    endtask
endmodule
`default_nettype wire

// [bench/cascaded_timer_unit_compare_tb_top.sv]
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin num_errors++; \
    $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module cascaded_timer_unit_compare_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NS [7] = '{1, 2, 8, 32, 64, 1024, 8192};
    localparam logic [31:0] RST_V [6] = '{0, 0, 32'h0000_FFFF, 32'h0000_FFFF, 0, 0};
    localparam logic [15:0] LD [4] = '{16'hFFFF, 16'h00FF, 16'h00FF, 16'h00FF};
    localparam logic [15:0] EX [4] = '{16'h0000, 16'h0100, 16'h0100, 16'h0101};
    localparam logic [3:0] CK [4] = '{4'h1, 4'h1, 4'h2, 4'h3};
    localparam logic [31:0] F_ADC = 32'h1 << ctu_pkg::ADC_BIT;
    localparam logic [31:0] F_DA = 32'h1 << ctu_pkg::DTC_A_BIT;
    localparam logic [31:0] F_DB = 32'h1 << ctu_pkg::DTC_B_BIT;
    localparam logic [31:0] F_PER = 32'h1 << ctu_pkg::PERIODIC_BIT;
    localparam logic [31:0] F_LVL = 32'h1 << ctu_pkg::LEVEL_BIT;
    localparam logic [31:0] F_OFF = 32'h1 << ctu_pkg::OUT_OFF_BIT;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, pin, oe, adc, data_transfer_controller, irq, clk_pin, rst_pin, rerr;
    int num_errors = 0, n_tests = 0, n_adc = 0, n_dtc = 0;

    ctu_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_count_clock_in(clk_pin), .ext_counter_reset_in(rst_pin),
        .timer_output_pin(pin), .timer_output_pin_oe(oe), .adc_start_req(adc),
        .dtc_req(data_transfer_controller), .irq(irq));
    ctu_pin_model u_pins (.pclk(pclk), .clk_pin(clk_pin), .rst_pin(rst_pin));

    initial forever #2 pclk = ~pclk;

    always @(posedge pclk) begin
        n_adc <= n_adc + int'(adc === 1'b1);
        n_dtc <= n_dtc + int'(data_transfer_controller === 1'b1);
    end

    // ------------------------------------------------------------
    // Bus and event tasks
    // ------------------------------------------------------------
    // The answer is taken at the rising edge that completes the access, before that edge's
    // updates land; the task then returns at the falling edge so outputs are settled.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        `CHK("pready", 1'b1, pready)
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic wait_pulse(input logic use_dtc, input int lim);
        int t;
        t = 0;
        @(negedge pclk);
        while ((use_dtc ? data_transfer_controller : adc) !== 1'b1 && t < lim) begin
            @(negedge pclk);
            t++;
        end
        `CHK("pulse", 1'b1, (use_dtc ? data_transfer_controller : adc))
    endtask

    function automatic logic [31:0] cfg(input logic [3:0] c, input logic [2:0] r,
                                        input logic [31:0] f);
        cfg = 32'(c) | (32'(r) << ctu_pkg::CLR_LSB) | f;
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        num_errors++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        logic [1:0] act;
        logic p1, ex;
        int a0, d0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK("reset value", RST_V[i], rd)
        end
        `CHK("oe after reset", 1'b1, oe)
        apb(1'b0, 8'h18, 32'h0);
        `CHK("unmapped err", 1'b1, rerr)
        apb(1'b1, ctu_pkg::ADDR_STATUS, 32'h0000_0007);
        apb(1'b0, ctu_pkg::ADDR_STATUS, 32'h0);
        `CHK("status write", 32'h0, rd)
        apb(1'b1, ctu_pkg::ADDR_COUNT, 32'h0000_0005);
        repeat (20) @(posedge pclk);
        apb(1'b0, ctu_pkg::ADDR_COUNT, 32'h0);
        `CHK("count halted", 32'h5, rd)
        apb(1'b1, ctu_pkg::ADDR_COUNT, 32'h0);
        apb(1'b1, ctu_pkg::ADDR_MATCH_A, 32'h0000_0001);
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, ctu_pkg::ADDR_CTRL, cfg(4'(4 + i), ctu_pkg::CLR_MATCH_A, F_ADC | F_DA));
            wait_pulse(1'b0, 4 * NS[i] + 20);
            a0 = n_adc;
            d0 = n_dtc;
            repeat (4 * NS[i]) @(negedge pclk);
            `CHK("adc pulses", 2, n_adc - a0)
            `CHK("dtc pulses", 2, n_dtc - d0)
        end
        apb(1'b1, ctu_pkg::ADDR_CTRL, cfg(ctu_pkg::CLK_DIV_1, ctu_pkg::CLR_MATCH_A, F_DA));
        wait_pulse(1'b1, 20);
        a0 = n_adc;
        d0 = n_dtc;
        repeat (8) @(negedge pclk);
        `CHK("adc off", 0, n_adc - a0)
        `CHK("dtc only", 4, n_dtc - d0)
        apb(1'b1, ctu_pkg::ADDR_MASK, 32'h0000_0002);
        `CHK("irq on", 1'b1, irq)
        apb(1'b1, ctu_pkg::ADDR_CTRL, 32'h0);
        apb(1'b0, ctu_pkg::ADDR_STATUS, 32'h0);
        `CHK("status", 32'h2, rd)
        apb(1'b0, ctu_pkg::ADDR_STATUS, 32'h0);
        `CHK("status cleared", 32'h0, rd)
        `CHK("irq off", 1'b0, irq)
        for (int k = 0; k < 6; k++) begin
            act = 2'(k % 3 + 1);
            apb(1'b1, ctu_pkg::ADDR_MATCH_A, k < 3 ? 32'h1 : 32'hFF);
            apb(1'b1, ctu_pkg::ADDR_MATCH_B, 32'h0000_0001);
            apb(1'b1, ctu_pkg::ADDR_CTRL, k < 3 ?
                cfg(ctu_pkg::CLK_DIV_1, ctu_pkg::CLR_MATCH_A, F_DA | 32'(act) << 10) :
                cfg(ctu_pkg::CLK_DIV_1, ctu_pkg::CLR_MATCH_B, F_DB | 32'(act) << 12));
            apb(1'b1, ctu_pkg::ADDR_COUNT, 32'h0);
            wait_pulse(1'b1, 20);
            p1 = pin;
            wait_pulse(1'b1, 20);
            ex = act == ctu_pkg::OUT_LOW ? 1'b0 : act == ctu_pkg::OUT_HIGH ? 1'b1 : ~p1;
            `CHK("pin action", ex, pin)
        end
        apb(1'b1, ctu_pkg::ADDR_CTRL, 32'h0);
        apb(1'b0, ctu_pkg::ADDR_STATUS, 32'h0);
        apb(1'b1, ctu_pkg::ADDR_MASK, 32'h0000_0001);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, ctu_pkg::ADDR_CTRL, cfg(CK[k], ctu_pkg::CLR_NONE, 32'h0));
            apb(1'b1, ctu_pkg::ADDR_COUNT, 32'(LD[k]));
            u_pins.pulse_clk();
            repeat (8) @(posedge pclk);
            if (k == 0) `CHK("irq overflow", 1'b1, irq)
            apb(1'b0, ctu_pkg::ADDR_COUNT, 32'h0);
            `CHK("ext count", 32'(EX[k]), rd)
        end
        apb(1'b0, ctu_pkg::ADDR_STATUS, 32'h0);
        // The count also passes the match A value of 0xFF, so that flag is set too.
        `CHK("overflow flag", 32'h3, rd)
        apb(1'b1, ctu_pkg::ADDR_CTRL, cfg(ctu_pkg::CLK_OFF, ctu_pkg::CLR_RST_HIGH, 32'h0));
        apb(1'b1, ctu_pkg::ADDR_COUNT, 32'h0000_1234);
        u_pins.hold(1'b0, 1'b1);
        apb(1'b0, ctu_pkg::ADDR_COUNT, 32'h0);
        `CHK("level clear", 32'h0, rd)
        u_pins.hold(1'b0, 1'b0);
        apb(1'b1, ctu_pkg::ADDR_CTRL, cfg(ctu_pkg::CLK_OFF, ctu_pkg::CLR_RST_EDGE, 32'h0));
        apb(1'b1, ctu_pkg::ADDR_COUNT, 32'h0000_0055);
        apb(1'b0, ctu_pkg::ADDR_COUNT, 32'h0);
        `CHK("no edge yet", 32'h55, rd)
        u_pins.hold(1'b0, 1'b1);
        u_pins.hold(1'b0, 1'b0);
        apb(1'b0, ctu_pkg::ADDR_COUNT, 32'h0);
        `CHK("edge clear", 32'h0, rd)
        apb(1'b1, ctu_pkg::ADDR_CTRL, F_PER | F_LVL);
        @(negedge pclk);
        `CHK("start high", 1'b1, pin)
        // The start level is loaded on entry to periodic mode, so leave it first.
        apb(1'b1, ctu_pkg::ADDR_CTRL, 32'h0);
        apb(1'b1, ctu_pkg::ADDR_CTRL, F_PER);
        @(negedge pclk);
        `CHK("start low", 1'b0, pin)
        apb(1'b1, ctu_pkg::ADDR_MATCH_A, 32'h0000_0001);
        apb(1'b1, ctu_pkg::ADDR_MATCH_B, 32'h0000_0003);
        apb(1'b1, ctu_pkg::ADDR_CTRL, F_PER | F_LVL | F_DA | F_DB | F_ADC | 32'h4);
        wait_pulse(1'b0, 20);
        a0 = n_adc;
        d0 = n_dtc;
        `CHK("width point", 1'b0, pin)
        wait_pulse(1'b1, 20);
        `CHK("period end", 1'b1, pin)
        repeat (6) @(negedge pclk);
        `CHK("periodic dtc", 4, n_dtc - d0)
        `CHK("periodic adc", 2, n_adc - a0)
        apb(1'b1, ctu_pkg::ADDR_CTRL, F_PER | F_OFF);
        @(negedge pclk);
        `CHK("output off", 1'b0, oe)
        report_and_stop();
    end
endmodule
`undef CHK
`default_nettype wire
